/* File: design/keypad_pkg.sv */
package keypad_pkg;
   // register word indexes on the 32-bit bus: byte address = 4*index
   localparam logic [7:0] level_select_index = 8'h8d;
   localparam logic [7:0] irq_mask_index     = 8'h8e;
   localparam logic [7:0] hit_flags_index    = 8'h8f;
   localparam logic [7:0] control_index      = 8'h90;
   localparam logic [7:0] irq_status_index   = 8'h91;
   localparam logic [7:0] irq_enable_index   = 8'h92;
   localparam logic [7:0] reset_byte         = 8'h00;
   localparam int         key_count          = 8;
   localparam int         addr_width         = 10;
   // control register fields
   localparam int         ctl_global_en_bit  = 0;
   localparam int         ctl_sleep_bit      = 1;
   // event status fields
   localparam int         evt_flag_bit       = 0;
   localparam int         evt_wake_bit       = 1;

   typedef struct packed {
      logic [addr_width-1:0] address;
      logic                  read;
      logic                  write;
      logic [31:0]           writedata;
      logic [3:0]            byteenable;
   } bus_req_s;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } bus_rsp_s;
endpackage : keypad_pkg

/* File: design/keypad_level_interrupt.sv */
// What this block does
// - eight key inputs are separate sources sharing one interrupt request.
// - flag bit x is set while input x sits at its active level.
// - level-select zero means active low; one means active high.
// - any write to the flag register with byte lane zero enabled clears every flag whose input is not still at its active level.
// - a flag requests an interrupt only while its mask bit is one.
// - mask bit zero leaves the pin a plain input, no interrupt part.
// - one global enable gates the combined keypad request.
// - an active level on an enabled input can wake the chip from sleep.
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module keypad_level_interrupt #(
   parameter int key_width = 8
) (
   input  wire logic                   clock,
   input  wire logic                   resetn,
   input  wire keypad_pkg::bus_req_s   bus_req,
   output      keypad_pkg::bus_rsp_s   bus_rsp,
   input  wire logic [key_width-1:0]   keypad_input_pin,
   output      logic [key_width-1:0]   port_a_pin,
   output      logic                   key_irq,
   output      logic                   wake_request,
   output      logic                   irq
);
   import keypad_pkg::*;

   // register state
   logic [key_width-1:0] key_level_select, next_key_level_select;
   logic [key_width-1:0] key_irq_mask,     next_key_irq_mask;
   logic [key_width-1:0] key_hit_flags,    next_key_hit_flags;
   logic [7:0]           control,          next_control;
   logic [7:0]           irq_status,       next_irq_status;
   logic [7:0]           irq_enable,       next_irq_enable;
   logic [31:0]          readdata,         next_readdata;
   logic                 answer,           next_answer;
   logic [key_width-1:0] pin_seen,         next_pin_seen;
   logic                 key_irq_q,        next_key_irq_q;
   logic                 wake_q,           next_wake_q;
   logic                 irq_q,            next_irq_q;

   logic [key_width-1:0] active_hit;
   logic                 access, wr_hit, rd_hit;
   logic [7:0]           word_index;

   // active-level compare per input
   genvar g;
   generate
      for (g = 0; g < key_width; g++) begin : g_level
         assign active_hit[g] = (keypad_input_pin[g] == key_level_select[g]);
      end
   endgenerate

   // bus decode: one cycle wait, answer on second cycle
   function automatic logic is_write_to(input logic [7:0] idx, input logic [7:0] target);
      is_write_to = (idx == target);
   endfunction : is_write_to

   assign word_index = bus_req.address[9:2];
   assign access     = (bus_req.read || bus_req.write) && !answer;
   assign wr_hit     = access && bus_req.write && bus_req.byteenable[0];
   assign rd_hit     = access && bus_req.read;

   // next-state computation
   always_comb begin
      logic flag_evt;
      logic wake_evt;
      flag_evt              = 1'b0;
      wake_evt              = 1'b0;
      next_key_level_select = key_level_select;
      next_key_irq_mask     = key_irq_mask;
      next_key_hit_flags    = key_hit_flags;
      next_control          = control;
      next_irq_status       = irq_status;
      next_irq_enable       = irq_enable;
      next_readdata         = readdata;
      next_answer           = access;
      // writes
      if (wr_hit && is_write_to(word_index, level_select_index)) begin
         next_key_level_select = bus_req.writedata[key_width-1:0];
      end
      if (wr_hit && is_write_to(word_index, irq_mask_index)) begin
         next_key_irq_mask = bus_req.writedata[key_width-1:0];
      end
      if (wr_hit && is_write_to(word_index, control_index)) begin
         next_control = bus_req.writedata[7:0];
      end
      if (wr_hit && is_write_to(word_index, irq_enable_index)) begin
         next_irq_enable = bus_req.writedata[7:0];
      end
      // a write with byte lane zero clears all flags, but a pin still active sets again
      if (wr_hit && is_write_to(word_index, hit_flags_index)) begin
         next_key_hit_flags = '0;
      end
      next_key_hit_flags = next_key_hit_flags | active_hit;
      flag_evt = |(active_hit & ~key_hit_flags & key_irq_mask);
      wake_evt = control[ctl_sleep_bit] && |(active_hit & key_irq_mask);
      // reads
      if (rd_hit) begin
         next_readdata = 32'h0000_0000;
         unique case (word_index)
            level_select_index: next_readdata[key_width-1:0] = key_level_select;
            irq_mask_index:     next_readdata[key_width-1:0] = key_irq_mask;
            hit_flags_index:    next_readdata[key_width-1:0] = key_hit_flags;
            control_index:      next_readdata[7:0] = control;
            irq_status_index:   next_readdata[7:0] = irq_status;
            irq_enable_index:   next_readdata[7:0] = irq_enable;
            default:            next_readdata = 32'h0000_0000;
         endcase
         if (word_index == irq_status_index) begin
            next_irq_status = 8'h00;
         end
      end
      // event capture; set wins over read clear
      if (flag_evt) begin
         next_irq_status[evt_flag_bit] = 1'b1;
      end
      if (wake_evt) begin
         next_irq_status[evt_wake_bit] = 1'b1;
      end
      next_pin_seen = keypad_input_pin;
      // combined request: masked flags, global enable
      next_key_irq_q = control[ctl_global_en_bit] && |(key_hit_flags & key_irq_mask);
      next_wake_q    = control[ctl_sleep_bit] && |(active_hit & key_irq_mask);
      next_irq_q     = |(next_irq_status & irq_enable);
   end

   // registers
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         key_level_select <= '0;
         key_irq_mask     <= '0;
         key_hit_flags    <= '0;
         control          <= reset_byte;
         irq_status       <= reset_byte;
         irq_enable       <= reset_byte;
         readdata         <= 32'h0000_0000;
         answer           <= 1'b0;
         pin_seen         <= '0;
         key_irq_q        <= 1'b0;
         wake_q           <= 1'b0;
         irq_q            <= 1'b0;
      end else begin
         key_level_select <= next_key_level_select;
         key_irq_mask     <= next_key_irq_mask;
         key_hit_flags    <= next_key_hit_flags;
         control          <= next_control;
         irq_status       <= next_irq_status;
         irq_enable       <= next_irq_enable;
         readdata         <= next_readdata;
         answer           <= next_answer;
         pin_seen         <= next_pin_seen;
         key_irq_q        <= next_key_irq_q;
         wake_q           <= next_wake_q;
         irq_q            <= next_irq_q;
      end
   end

   // outputs from flip-flops
   assign bus_rsp.readdata    = readdata;
   assign bus_rsp.waitrequest = !answer;
   assign port_a_pin          = pin_seen;
   assign key_irq             = key_irq_q;
   assign wake_request        = wake_q;
   assign irq                 = irq_q;

   // checks
   a_flag_sets_active: assert property (@(posedge clock) disable iff (!resetn)
      (|active_hit) |=> ((key_hit_flags & $past(active_hit)) == $past(active_hit)))
      else $error("active input did not set its flag");

   a_flag_write_clear: assert property (@(posedge clock) disable iff (!resetn)
      (wr_hit && word_index == hit_flags_index) |=> (key_hit_flags == $past(active_hit)))
      else $error("flag write did not clear flags");

   a_flag_resets_again: assert property (@(posedge clock) disable iff (!resetn)
      (wr_hit && word_index == hit_flags_index && active_hit[0]) |=> key_hit_flags[0])
      else $error("active input flag not set again after clear");

   a_level_low_high: assert property (@(posedge clock) disable iff (!resetn)
      (!key_level_select[0] && !keypad_input_pin[0]) |=> key_hit_flags[0])
      else $error("low level select did not detect low");

   a_mask_gates_req: assert property (@(posedge clock) disable iff (!resetn)
      ((key_hit_flags & key_irq_mask) == '0) |=> !key_irq)
      else $error("unmasked request without masked flag");

   a_unmasked_no_irq: assert property (@(posedge clock) disable iff (!resetn)
      (key_irq_mask == '0) |=> !key_irq)
      else $error("pin with mask zero raised request");

   a_global_gate: assert property (@(posedge clock) disable iff (!resetn)
      (control[ctl_global_en_bit] && |(key_hit_flags & key_irq_mask)) |=> key_irq)
      else $error("enabled flag did not raise request");

   a_global_off: assert property (@(posedge clock) disable iff (!resetn)
      !control[ctl_global_en_bit] |=> !key_irq)
      else $error("request raised while globally disabled");

   a_wake_follow: assert property (@(posedge clock) disable iff (!resetn)
      (control[ctl_sleep_bit] && |(active_hit & key_irq_mask)) |=> wake_request)
      else $error("wake not requested on active enabled input");

   a_shared_source: assert property (@(posedge clock) disable iff (!resetn)
      key_irq |-> $past(|(key_hit_flags & key_irq_mask)))
      else $error("request without any source");

   // named steps of a bus transfer and of a flag clear
   sequence s_request_taken;
      access;
   endsequence

   sequence s_answer_shown;
      !bus_rsp.waitrequest;
   endsequence

   sequence s_flag_write;
      wr_hit && (word_index == hit_flags_index);
   endsequence

   sequence s_flags_refill;
      (key_hit_flags == $past(active_hit));
   endsequence

   // a taken request is answered on the very next edge
   a_bus_answer_next: assert property (@(posedge clock) disable iff (!resetn)
      s_request_taken |=> s_answer_shown)
      else $error("taken request not answered next cycle");

   // the answer lasts one cycle only
   a_bus_answer_once: assert property (@(posedge clock) disable iff (!resetn)
      s_answer_shown |=> bus_rsp.waitrequest)
      else $error("answer held longer than one cycle");

   // an idle bus is never answered
   a_bus_idle_wait: assert property (@(posedge clock) disable iff (!resetn)
      (!bus_req.read && !bus_req.write) |=> bus_rsp.waitrequest)
      else $error("answer without a request");

   // clear and level re-detect land on the same edge
   a_flag_clear_refill: assert property (@(posedge clock) disable iff (!resetn)
      s_flag_write |=> s_flags_refill)
      else $error("flag clear did not refill active inputs");

   // flags stay set until the flag register is written
   a_flag_sticky_hold: assert property (@(posedge clock) disable iff (!resetn)
      !(wr_hit && word_index == hit_flags_index)
      |=> ((key_hit_flags & $past(key_hit_flags)) == $past(key_hit_flags)))
      else $error("flag dropped without a write");

   // high level select detects a high input
   a_level_high_detect: assert property (@(posedge clock) disable iff (!resetn)
      (key_level_select[0] && keypad_input_pin[0]) |=> key_hit_flags[0])
      else $error("high level select did not detect high");

   // level select write lands at the answer
   a_level_write_lands: assert property (@(posedge clock) disable iff (!resetn)
      (wr_hit && word_index == level_select_index)
      |=> (key_level_select == $past(bus_req.writedata[key_width-1:0])))
      else $error("level select write lost");

   // mask write lands at the answer
   a_mask_write_lands: assert property (@(posedge clock) disable iff (!resetn)
      (wr_hit && word_index == irq_mask_index)
      |=> (key_irq_mask == $past(bus_req.writedata[key_width-1:0])))
      else $error("mask write lost");

   // a write without lane zero changes nothing
   a_lane_zero_ignored: assert property (@(posedge clock) disable iff (!resetn)
      (access && bus_req.write && !bus_req.byteenable[0])
      |=> ($stable(key_irq_mask) && $stable(key_level_select)))
      else $error("write without lane zero took effect");

   // flag read returns the flags of the taking edge
   a_flag_read_data: assert property (@(posedge clock) disable iff (!resetn)
      (rd_hit && word_index == hit_flags_index)
      |=> (bus_rsp.readdata[key_width-1:0] == $past(key_hit_flags)))
      else $error("flag read returned wrong data");

   // a new masked flag marks the status, even during its read
   a_status_set_wins: assert property (@(posedge clock) disable iff (!resetn)
      (|(active_hit & ~key_hit_flags & key_irq_mask)) |=> irq_status[evt_flag_bit])
      else $error("new masked flag not marked in status");

   // a wake event marks the status
   a_status_wake_set: assert property (@(posedge clock) disable iff (!resetn)
      (control[ctl_sleep_bit] && |(active_hit & key_irq_mask)) |=> irq_status[evt_wake_bit])
      else $error("wake event not marked in status");

   // status read clears when no event competes
   a_status_read_clear: assert property (@(posedge clock) disable iff (!resetn)
      (rd_hit && word_index == irq_status_index
       && !(|(active_hit & ~key_hit_flags & key_irq_mask))
       && !(control[ctl_sleep_bit] && |(active_hit & key_irq_mask)))
      |=> (irq_status == 8'h00))
      else $error("status read did not clear");

   // no enabled status bit, no interrupt
   a_irq_quiet_off: assert property (@(posedge clock) disable iff (!resetn)
      (irq_enable == 8'h00) |=> !irq)
      else $error("interrupt raised with all status bits disabled");

   // plain input view follows the pins one cycle late
   a_port_plain_copy: assert property (@(posedge clock) disable iff (!resetn)
      1'b1 |=> (port_a_pin == $past(keypad_input_pin)))
      else $error("plain input view wrong");

   // no wake request while the sleep enable is off
   a_wake_sleep_off: assert property (@(posedge clock) disable iff (!resetn)
      !control[ctl_sleep_bit] |=> !wake_request)
      else $error("wake requested while disabled");

   // the top input is a source of the shared request as well
   a_req_top_source: assert property (@(posedge clock) disable iff (!resetn)
      (control[ctl_global_en_bit] && key_hit_flags[key_width-1] && key_irq_mask[key_width-1])
      |=> key_irq)
      else $error("top input flag did not raise request");
endmodule : keypad_level_interrupt

/* File: bench/keypad_switches.sv */
`timescale 1ns/100ps
module keypad_switches (
   input  wire logic [7:0] pressed,
   output      logic [7:0] keypad_input_pin
);
   // pull-ups hold released keys high, a pressed key shorts its line low
   assign keypad_input_pin = ~pressed;
endmodule : keypad_switches

/* File: bench/keypad_level_interrupt_bench.sv */
`timescale 1ns/100ps
module keypad_level_interrupt_bench;
   import keypad_pkg::*;
   logic        clock      = 1'b0;
   logic        resetn     = 1'b0;
   bus_req_s    bus_req    = '0;
   bus_rsp_s    bus_rsp;
   logic [7:0]  pressed    = 8'h00;
   logic [7:0]  key_pin;
   logic [7:0]  port_a_pin;
   logic        key_irq;
   logic        wake_request;
   logic        irq;
   logic [31:0] rd;
   int          bad_count  = 0;
   int          num_checks = 0;
   int          cycles     = 0;

   // 40 mhz clock and hang guard
   always #12.5 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         final_report();
      end
   end

   keypad_switches i_keys (.pressed(pressed), .keypad_input_pin(key_pin));
   keypad_level_interrupt i_dut (.clock(clock), .resetn(resetn), .bus_req(bus_req),
      .bus_rsp(bus_rsp), .keypad_input_pin(key_pin), .port_a_pin(port_a_pin),
      .key_irq(key_irq), .wake_request(wake_request), .irq(irq));

   // one avalon access, held until waitrequest is sampled low
   task automatic access(input logic [7:0] index, input logic wr, input logic [7:0] data);
      @(posedge clock);
      bus_req.address <= {index, 2'b00};
      bus_req.read <= ~wr;
      bus_req.write <= wr;
      bus_req.writedata <= {24'h000000, data};
      bus_req.byteenable <= 4'hf;
      @(posedge clock);
      while (bus_rsp.waitrequest !== 1'b0) @(posedge clock);
      rd = bus_rsp.readdata;
      bus_req.read <= 1'b0;
      bus_req.write <= 1'b0;
   endtask : access

   task automatic compare(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : compare

   task automatic read_check(input logic [7:0] index, input logic [7:0] exp);
      access(index, 1'b0, 8'h00);
      compare(rd, {24'h000000, exp});
   endtask : read_check

   // change the keys, then let the registered outputs land
   task automatic press(input logic [7:0] keys);
      @(posedge clock);
      pressed <= keys;
      repeat (4) @(posedge clock);
      #1;
   endtask : press

   task automatic final_report();
      if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : final_report

   // main sequence
   initial begin
      repeat (8) @(posedge clock);
      resetn <= 1'b1;
      read_check(level_select_index, 8'h00);
      read_check(irq_mask_index, 8'h00);
      read_check(hit_flags_index, 8'h00);
      read_check(8'h20, 8'h00);
      access(irq_mask_index, 1'b1, 8'h24);
      read_check(irq_mask_index, 8'h24);
      access(control_index, 1'b1, 8'h01);
      access(irq_enable_index, 1'b1, 8'h01);
      press(8'h24);
      read_check(hit_flags_index, 8'h24);
      compare(key_irq, 1'b1);
      compare(irq, 1'b1);
      compare(port_a_pin, 8'hdb);
      read_check(irq_status_index, 8'h01);
      press(8'h04);
      compare(irq, 1'b0);
      access(hit_flags_index, 1'b1, 8'h00);
      read_check(hit_flags_index, 8'h04);
      press(8'h00);
      access(hit_flags_index, 1'b1, 8'hff);
      read_check(hit_flags_index, 8'h00);
      press(8'h04);
      access(irq_mask_index, 1'b1, 8'h00);
      press(8'h04);
      compare(key_irq, 1'b0);
      access(irq_mask_index, 1'b1, 8'h04);
      press(8'h04);
      compare(key_irq, 1'b1);
      access(control_index, 1'b1, 8'h00);
      press(8'h04);
      compare(key_irq, 1'b0);
      access(level_select_index, 1'b1, 8'h80);
      press(8'h00);
      access(hit_flags_index, 1'b1, 8'h00);
      read_check(hit_flags_index, 8'h80);
      press(8'h80);
      access(hit_flags_index, 1'b1, 8'h00);
      read_check(hit_flags_index, 8'h00);
      access(control_index, 1'b1, 8'h02);
      press(8'h04);
      compare(wake_request, 1'b1);
      access(irq_mask_index, 1'b1, 8'h00);
      press(8'h04);
      compare(wake_request, 1'b0);
      compare(irq, 1'b1);
      read_check(irq_status_index, 8'h03);
      read_check(irq_status_index, 8'h00);
      final_report();
   end
endmodule : keypad_level_interrupt_bench
